/* File: design/bdcm_top.sv */
`default_nettype none
module bdcm_top #(
  parameter int CYC_PER_MS = bdcm_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               srst_i,
  input  wire logic               ce_i,
  // Measured rms currents in mA from the current sensing path
  input  wire logic signed [31:0] field_rms_i,
  input  wire logic signed [31:0] torque_rms_i,
  input  wire logic signed [31:0] phase1_rms_i,
  input  wire logic signed [31:0] phase2_rms_i,
  // Drive state
  input  wire logic               closed_loop_i,
  input  wire logic               block_arm_i,
  input  wire logic        [31:0] max_current_i,
  // Object entry access
  input  wire logic        [3:0]  obj_sel_i,
  input  wire logic               obj_wr_i,
  input  wire logic signed [31:0] obj_wdata_i,
  output logic signed [31:0]      obj_rdata_o,
  output logic                    obj_err_o,
  // Block detection
  output logic                    block_detect_o,
  output logic                    block_push_o,
  output logic                    block_done_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_DONE} bdcm_state_t;

  // ***********************************************
  // Registers
  // ***********************************************
  logic signed [31:0] limit_ff;
  logic signed [31:0] time_ff;
  logic signed [31:0] field_pk;
  logic signed [31:0] torque_pk;
  logic signed [31:0] phase1_pk;
  logic signed [31:0] phase2_pk;
  logic signed [31:0] rdata_ff;
  logic               err_ff;
  logic               detect_ff;
  logic [31:0]        thresh_ff;
  logic [31:0]        ms_left_ff;
  logic [31:0]        nxt_ms_left;
  logic [31:0]        tick_ff;
  logic [31:0]        nxt_tick;
  bdcm_state_t        state_ff;
  bdcm_state_t        nxt_state;

  // ***********************************************
  // Peak conversion
  // ***********************************************
  logic signed [31:0] field_in;
  logic signed [31:0] torque_in;

  // Zero is applied before scaling so reads are exactly zero
  assign field_in  = closed_loop_i ? field_rms_i : 32'sh0;
  assign torque_in = closed_loop_i ? torque_rms_i : 32'sh0;

  bdcm_peak_scale u_field (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rms_i      (field_in),
    .peak_o     (field_pk)
  );
  bdcm_peak_scale u_torque (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rms_i      (torque_in),
    .peak_o     (torque_pk)
  );
  bdcm_peak_scale u_phase1 (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rms_i      (phase1_rms_i),
    .peak_o     (phase1_pk)
  );
  bdcm_peak_scale u_phase2 (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rms_i      (phase2_rms_i),
    .peak_o     (phase2_pk)
  );

  // ***********************************************
  // Entry decode
  // ***********************************************
  logic               sel_known;
  logic               wr_limit;
  logic               wr_time;
  logic signed [31:0] rd_mux;

  function automatic logic is_rw(input logic [3:0] sel);
    is_rw = (sel == bdcm_pkg::SEL_BLK_LIMIT) || (sel == bdcm_pkg::SEL_BLK_TIME);
  endfunction

  assign sel_known = is_rw(obj_sel_i)
                   || (obj_sel_i == bdcm_pkg::SEL_CUR_COUNT)
                   || (obj_sel_i == bdcm_pkg::SEL_BLK_COUNT)
                   || ((obj_sel_i >= bdcm_pkg::SEL_FIELD_CUR)
                       && (obj_sel_i <= bdcm_pkg::SEL_PHASE2_CUR));
  assign wr_limit  = obj_wr_i && (obj_sel_i == bdcm_pkg::SEL_BLK_LIMIT);
  assign wr_time   = obj_wr_i && (obj_sel_i == bdcm_pkg::SEL_BLK_TIME);

  // Currents read in mA, peak, signed 32 bit
  assign rd_mux =
      (obj_sel_i == bdcm_pkg::SEL_CUR_COUNT)  ? {24'h0, bdcm_pkg::CUR_COUNT_RST} :
      (obj_sel_i == bdcm_pkg::SEL_FIELD_CUR)  ? field_pk :
      (obj_sel_i == bdcm_pkg::SEL_TORQUE_CUR) ? torque_pk :
      (obj_sel_i == bdcm_pkg::SEL_PHASE1_CUR) ? phase1_pk :
      (obj_sel_i == bdcm_pkg::SEL_PHASE2_CUR) ? phase2_pk :
      (obj_sel_i == bdcm_pkg::SEL_BLK_COUNT)  ? {24'h0, bdcm_pkg::BLK_COUNT_RST} :
      (obj_sel_i == bdcm_pkg::SEL_BLK_LIMIT)  ? limit_ff :
      (obj_sel_i == bdcm_pkg::SEL_BLK_TIME)   ? time_ff :
      32'sh0;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      limit_ff <= bdcm_pkg::BLK_LIMIT_RST;
      time_ff  <= bdcm_pkg::BLK_TIME_RST;
      rdata_ff <= 32'sh0;
      err_ff   <= 1'b0;
    end else if (ce_i) begin
      if (wr_limit) limit_ff <= obj_wdata_i;
      if (wr_time)  time_ff  <= obj_wdata_i;
      rdata_ff <= rd_mux;
      // Writes to read-only or unknown entries are refused
      err_ff   <= !sel_known || (obj_wr_i && !is_rw(obj_sel_i));
    end
  end

  assign obj_rdata_o = rdata_ff;
  assign obj_err_o   = err_ff;

  // ***********************************************
  // Threshold
  // ***********************************************
  logic [31:0] pct_mag;
  logic [63:0] pct_prod;
  logic [31:0] pct_thresh;
  logic [31:0] nxt_thresh;

  assign pct_mag    = 32'(-limit_ff);
  // Percent of maximum current, truncated toward zero
  assign pct_prod   = 64'(max_current_i) * 64'(pct_mag);
  assign pct_thresh = 32'(pct_prod / 64'(bdcm_pkg::PCT_DIV));
  assign nxt_thresh = limit_ff[31] ? pct_thresh : 32'(limit_ff);

  // Registered to keep the divider out of the compare path
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      thresh_ff <= bdcm_pkg::BLK_LIMIT_RST;
    end else if (ce_i) begin
      thresh_ff <= nxt_thresh;
    end
  end

  // ***********************************************
  // Block detection
  // ***********************************************
  logic [31:0] torque_mag;
  logic        over_limit;

  // Torque component magnitude judges the load on the stop
  assign torque_mag = torque_pk[31] ? 32'(-torque_pk) : 32'(torque_pk);
  assign over_limit = torque_mag > thresh_ff;

  always_comb begin
    nxt_state   = state_ff;
    nxt_ms_left = ms_left_ff;
    nxt_tick    = tick_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (block_arm_i && over_limit) begin
          nxt_state   = ST_PUSH;
          nxt_tick    = 32'(CYC_PER_MS - 1);
          // Negative time is treated as zero push time
          nxt_ms_left = time_ff[31] ? 32'h0 : 32'(time_ff);
          if (time_ff[31] || time_ff == 32'sh0) nxt_state = ST_DONE;
        end
      end
      ST_PUSH: begin
        if (tick_ff == 32'h0) begin
          nxt_tick    = 32'(CYC_PER_MS - 1);
          nxt_ms_left = ms_left_ff - 32'h1;
          if (ms_left_ff == 32'h1) nxt_state = ST_DONE;
        end else begin
          nxt_tick = tick_ff - 32'h1;
        end
      end
      ST_DONE: begin
        if (!block_arm_i) nxt_state = ST_IDLE;
      end
    endcase
    if (!block_arm_i) nxt_state = ST_IDLE;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff   <= ST_IDLE;
      ms_left_ff <= 32'h0;
      tick_ff    <= 32'h0;
      detect_ff  <= 1'b0;
    end else if (ce_i) begin
      state_ff   <= nxt_state;
      ms_left_ff <= nxt_ms_left;
      tick_ff    <= nxt_tick;
      detect_ff  <= (state_ff == ST_IDLE) && (nxt_state != ST_IDLE);
    end
  end

  assign block_detect_o = detect_ff;
  assign block_push_o   = (state_ff == ST_PUSH);
  assign block_done_o   = (state_ff == ST_DONE);
endmodule
`default_nettype wire

/* File: design/bdcm_pkg.sv */
// Behaviour
// - A block is declared when the measured motor current rises above the block current limit.
// - A positive limit setting is a threshold in milliamperes.
// - A negative limit setting is a percentage, by magnitude, of the maximum motor current.
// - After detection the drive keeps pushing against the block for the set time in ms.
// - Every reported motor current is in milliamperes.
// - Every reported current is a peak value, rms times the square root of two.
// - Entry one holds the field-forming current and entry two the torque-forming current.
// - Entries three and four hold the first and second phase currents.
// - Without closed-loop control the field and torque entries read zero.
`default_nettype none
package bdcm_pkg;
  // ***********************************************
  // Object entries
  // ***********************************************
  localparam logic [3:0] SEL_CUR_COUNT   = 4'h0;
  localparam logic [3:0] SEL_FIELD_CUR   = 4'h1;
  localparam logic [3:0] SEL_TORQUE_CUR  = 4'h2;
  localparam logic [3:0] SEL_PHASE1_CUR  = 4'h3;
  localparam logic [3:0] SEL_PHASE2_CUR  = 4'h4;
  localparam logic [3:0] SEL_BLK_COUNT   = 4'h8;
  localparam logic [3:0] SEL_BLK_LIMIT   = 4'h9;
  localparam logic [3:0] SEL_BLK_TIME    = 4'hA;
  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [7:0]  CUR_COUNT_RST  = 8'h04;
  localparam logic [7:0]  BLK_COUNT_RST  = 8'h02;
  localparam logic [31:0] BLK_LIMIT_RST  = 32'h000005DC;
  localparam logic [31:0] BLK_TIME_RST   = 32'h000000C8;
  // ***********************************************
  // Timing
  // ***********************************************
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          MS_PER_S       = 1000;
  localparam int          CYC_PER_MS     = CLK_HZ / MS_PER_S;
  // Peak scale: sqrt(2) as Q16 fraction (92682/65536)
  localparam logic [17:0] SQRT2_Q16      = 18'h16A0A;
  localparam int          SQRT2_SHIFT    = 16;
  localparam logic [7:0]  PCT_DIV        = 8'h64;
endpackage
`default_nettype wire

/* File: design/bdcm_peak_scale.sv */
`default_nettype none
// Converts a signed rms value in mA to a registered peak value
module bdcm_peak_scale (
  // Clock
  input  wire logic               core_clk_i,
  input  wire logic               srst_i,
  input  wire logic               ce_i,
  // Data
  input  wire logic signed [31:0] rms_i,
  output logic signed [31:0]      peak_o
);
  logic signed [50:0] prod;
  logic signed [31:0] peak_ff;

  assign prod   = 51'(rms_i) * $signed({1'b0, bdcm_pkg::SQRT2_Q16});
  assign peak_o = peak_ff;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      peak_ff <= 32'sh0;
    end else if (ce_i) begin
      peak_ff <= 32'(prod >>> bdcm_pkg::SQRT2_SHIFT);
    end
  end
endmodule
`default_nettype wire

/* File: bench/bdcm_properties.sv */
`default_nettype none
module bdcm_properties #(parameter int CYC_PER_MS = 4) (
  input wire logic               core_clk_i, srst_i, ce_i, closed_loop_i, block_arm_i, obj_wr_i,
  input wire logic [3:0]         obj_sel_i,
  input wire logic signed [31:0] obj_wdata_i, obj_rdata_o,
  input wire logic               obj_err_o, block_detect_o, block_push_o, block_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  // A frozen clock enable holds every register, so nothing is judged then
  default disable iff (srst_i || !ce_i);
  sequence s_pulse; block_detect_o ##1 !block_detect_o; endsequence
  sequence s_lim_wr; obj_wr_i && obj_sel_i == 4'h9 ##1 obj_sel_i == 4'h9; endsequence
  AST_DETECT_PULSE: assert property (block_detect_o |-> s_pulse)
    else $error("detect pulse too long");
  AST_DETECT_PUSH: assert property (block_detect_o |-> block_push_o || block_done_o)
    else $error("no push after detect");
  AST_DISARM_IDLE: assert property (!block_arm_i |=>
    !(block_detect_o || block_push_o || block_done_o)) else $error("not idle when disarmed");
  AST_DONE_AFTER_PUSH: assert property ($fell(block_push_o) && $past(block_arm_i)
    && block_arm_i |-> block_done_o) else $error("push ended without done");
  AST_CUR_COUNT: assert property (obj_sel_i == 4'h0 |=> obj_rdata_o == 32'h4)
    else $error("entry count wrong");
  AST_LIMIT_READBACK: assert property (s_lim_wr |=> obj_rdata_o == $past(obj_wdata_i, 2))
    else $error("limit readback wrong");
  AST_FIELD_ZERO: assert property ((!closed_loop_i) [*2] ##0 obj_sel_i inside {4'h1, 4'h2}
    |=> obj_rdata_o == 32'h0) else $error("open loop current not zero");
  AST_RO_WRITE_ERR: assert property (obj_wr_i && !(obj_sel_i inside {4'h9, 4'hA})
    |=> obj_err_o) else $error("read-only write not refused");
endmodule
bind bdcm_top bdcm_properties #(.CYC_PER_MS(CYC_PER_MS)) i_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .closed_loop_i(closed_loop_i),
  .block_arm_i(block_arm_i), .obj_wr_i(obj_wr_i), .obj_sel_i(obj_sel_i),
  .obj_wdata_i(obj_wdata_i), .obj_rdata_o(obj_rdata_o), .obj_err_o(obj_err_o),
  .block_detect_o(block_detect_o), .block_push_o(block_push_o), .block_done_o(block_done_o));
`default_nettype wire

/* File: bench/bdcm_host_model.sv */
`default_nettype none
module bdcm_host_model (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        err_i,
  output logic [3:0]       sel_o,
  output logic             wr_o,
  output logic [31:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {sel_o, wr_o, wdata_o} = '0;
  // Request held over one rising edge, answer taken at the next fall
  task automatic access(input logic [3:0] s, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
    @(negedge core_clk_i);
    {sel_o, wr_o, wdata_o} = {s, w, wd};
    @(negedge core_clk_i);
    // Stale data inverted so a late sample cannot pass
    {wr_o, wdata_o} = {1'b0, ~wd};
    {rd, er} = {rdata_i, err_i};
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CPM = 4;
  logic clk = 1'b0, srst = 1'b1, cl = 1'b1, arm = 1'b0, ce = 1'b1, wr, err, e, det, push, done;
  logic [31:0] maxc = 32'h7D0, fld = '0, trq = '0, ph1 = '0, ph2 = '0, wdata, rdata, d;
  logic [3:0] sel;
  int num_errors = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  bdcm_top #(.CYC_PER_MS(CPM)) i_dut (.core_clk_i(clk), .srst_i(srst), .ce_i(ce),
    .field_rms_i(fld), .torque_rms_i(trq), .phase1_rms_i(ph1), .phase2_rms_i(ph2),
    .closed_loop_i(cl), .block_arm_i(arm), .max_current_i(maxc), .obj_sel_i(sel),
    .obj_wr_i(wr), .obj_wdata_i(wdata), .obj_rdata_o(rdata), .obj_err_o(err),
    .block_detect_o(det), .block_push_o(push), .block_done_o(done));
  bdcm_host_model i_host (.core_clk_i(clk), .rdata_i(rdata), .err_i(err), .sel_o(sel),
    .wr_o(wr), .wdata_o(wdata));
  function automatic logic [31:0] pk(input logic signed [31:0] r);
    return 32'((64'(r) * 64'sh16A0A) >>> 16);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [3:0] s, input logic [31:0] exp);
    i_host.access(s, 1'b0, 32'h0, d, e);
    check(d, exp);
  endtask
  // Limit, torque, then arm; push length counted in falling edges
  task automatic blk(input logic [31:0] lim, input logic [31:0] rms, input logic hit);
    int n;
    i_host.access(4'h9, 1'b1, lim, d, e);
    i_host.access(4'hA, 1'b1, 32'h2, d, e);
    trq = rms;
    repeat (3) @(negedge clk);
    arm = 1'b1;
    for (n = 0; det !== 1'b1 && n < 10; n++) @(negedge clk);
    check(32'(det), 32'(hit));
    for (n = 0; push === 1'b1 && n < 20; n++) @(negedge clk);
    check({n[30:0], done}, hit ? {31'(2 * CPM), 1'b1} : 32'h0);
    arm = 1'b0;
    trq = '0;
    @(negedge clk);
    check(32'(done), 32'h0);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    rd(4'h0, 32'h4);
    rd(4'h8, 32'h2);
    rd(4'h9, 32'h5DC);
    rd(4'hA, 32'hC8);
    i_host.access(4'h2, 1'b1, 32'h5, d, e);
    check(32'(e), 32'h1);
    i_host.access(4'h5, 1'b0, 32'h0, d, e);
    check(d, 32'h0);
    check(32'(e), 32'h1);
    // Frozen clock enable must swallow a write
    ce = 1'b0;
    i_host.access(4'h9, 1'b1, 32'h123, d, e);
    ce = 1'b1;
    rd(4'h9, 32'h5DC);
    $display("register test done");
    {fld, trq, ph1, ph2} = {32'h3E8, -32'sh1F4, 32'h1E240, -32'sh7};
    repeat (2) @(negedge clk);
    rd(4'h1, pk(fld));
    rd(4'h2, pk(trq));
    rd(4'h3, pk(ph1));
    rd(4'h4, pk(ph2));
    cl = 1'b0;
    rd(4'h1, 32'h0);
    rd(4'h2, 32'h0);
    cl = 1'b1;
    $display("current test done");
    blk(32'h3E8, 32'h320, 1'b1);
    blk(32'h3E8, 32'h2BC, 1'b0);
    blk(-32'sh46, 32'h3E8, 1'b1);
    blk(-32'sh46, 32'h3D4, 1'b0);
    $display("block test done");
    summarize();
  end
  // Whole run needs well under 500 cycles
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
